// ### logic/tc_engine.v
// Four-channel transfer controller: trigger logic, arbiter, engine.
// Assumes a byte-wide data bus slave that answers rd/wr with ack or err.
// How it works
// - Four channels, each with own state; all may be armed together.
// - Bursts move 1, 2, 4 or 8 bytes; a granted burst runs unbroken.
// - Block byte count per channel, 1 to 64K bytes.
// - Repeat counter repeats the block; transaction ends when exhausted.
// - Source and destination each fixed, increment or decrement per byte.
// - Optional address reload after burst, block or transaction end.
// - Start by software, peripheral request or event, per channel setting.
// - Each channel holds its own addresses, trigger and sizes.
// - Interrupt request on transaction done and on channel error.
// - Each channel has own interrupt enables and own request lines.
// - Paired channels start each other on completion, both directions.
// - Memory or peripheral on either side, but a burst is refused if its first destination address lies in the read-only storage window.
// - Mapped non-volatile storage may serve as a read-only source.
// - Transferred bytes optionally forwarded to the CRC generator.
// - A burst is refused if its first source address is in non-volatile storage while it is not mapped into data space.
`timescale 1ns/1ns
`include "tc_map.vh"
module tc_engine
(
  input  wire        ref_clk_i,
  input  wire        rst_n_i,
  input  wire [3:0]  ch_en_i,
  input  wire [63:0] ch_src_addr_i,
  input  wire [63:0] ch_dst_addr_i,
  input  wire [63:0] ch_blk_size_i,
  input  wire [31:0] ch_repeat_i,
  input  wire [7:0]  ch_burst_i,
  input  wire [7:0]  ch_src_mode_i,
  input  wire [7:0]  ch_dst_mode_i,
  input  wire [7:0]  ch_src_reload_i,
  input  wire [7:0]  ch_dst_reload_i,
  input  wire [7:0]  ch_trig_sel_i,
  input  wire [3:0]  ch_crc_en_i,
  input  wire [3:0]  ch_irq_done_en_i,
  input  wire [3:0]  ch_irq_err_en_i,
  input  wire [3:0]  sw_trig_i,
  input  wire [3:0]  periph_req_i,
  input  wire [3:0]  event_i,
  input  wire [3:0]  done_clr_i,
  input  wire [3:0]  err_clr_i,
  input  wire [1:0]  pair_link_i,
  input  wire        prio_rr_i,
  input  wire        nvm_mapped_i,
  output reg  [15:0] bus_addr_o,
  output reg         bus_rd_o,
  output reg         bus_wr_o,
  output reg  [7:0]  bus_wdata_o,
  input  wire [7:0]  bus_rdata_i,
  input  wire        bus_ack_i,
  input  wire        bus_err_i,
  output reg         crc_valid_o,
  output reg  [7:0]  crc_data_o,
  output wire [3:0]  ch_busy_o,
  output wire [3:0]  ch_done_o,
  output wire [3:0]  ch_err_o,
  output wire [3:0]  irq_done_o,
  output wire [3:0]  irq_err_o
);

  localparam ST_IDLE = 3'h0, ST_RUN = 3'h1, ST_RD = 3'h2;
  localparam ST_WR   = 3'h3, ST_END = 3'h4;

  reg [2:0]  state_q;
  reg [1:0]  ch_q, last_q;
  reg [3:0]  len_q, rd_n_q, wr_n_q;
  reg [3:0]  act_q, served_q, fin_q, fail_q;
  reg [3:0]  req_q, done_q, err_q;
  reg [15:0] src_q [0:3], dst_q [0:3];
  reg [16:0] blk_q [0:3];
  reg [8:0]  rep_q [0:3];

  wire       fifo_in_rdy, fifo_out_vld, push_w, pop_w, flush_w;
  wire [7:0] fifo_out;

  // Step one address by its mode
  function [15:0] step_addr;
    input [15:0] a;
    input [1:0]  m;
    begin
      case (m)
        `TC_AM_INC: step_addr = a + 16'h0001;
        `TC_AM_DEC: step_addr = a - 16'h0001;
        default:    step_addr = a;
      endcase
    end
  endfunction

  // True inside the mapped non-volatile window
  function in_nvm;
    input [15:0] a;
    begin
      in_nvm = (a >= `TC_NVM_LO) && (a <= `TC_NVM_HI);
    end
  endfunction

  // Per-channel triggers, pending requests and sticky flags
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_ch
      wire [1:0] sel_w  = ch_trig_sel_i[2*g+1:2*g];
      wire       link_w = pair_link_i[g/2] & fin_q[g^1];
      wire       trig_w = ((sel_w == `TC_TR_SW) & sw_trig_i[g]) |
                          ((sel_w == `TC_TR_PERIPH) & periph_req_i[g]) |
                          ((sel_w == `TC_TR_EVENT) & event_i[g]) |
                          link_w;
      // Software start holds the request until the transaction ends
      wire       used_w = served_q[g] & (sel_w != `TC_TR_SW);
      always @(posedge ref_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          req_q[g]  <= 1'b0;
          done_q[g] <= 1'b0;
          err_q[g]  <= 1'b0;
        end
        else
        begin
          req_q[g]  <= ch_en_i[g] & (trig_w |
                       (req_q[g] & ~(fin_q[g] | fail_q[g] | used_w)));
          // Set wins over a clear in the same cycle
          done_q[g] <= fin_q[g] | (done_q[g] & ~done_clr_i[g]);
          err_q[g]  <= fail_q[g] | (err_q[g] & ~err_clr_i[g]);
        end
      end
      // Separate request lines per channel
      assign irq_done_o[g] = done_q[g] & ch_irq_done_en_i[g];
      assign irq_err_o[g]  = err_q[g] & ch_irq_err_en_i[g];
    end
  endgenerate

  assign ch_busy_o = act_q;
  assign ch_done_o = done_q;
  assign ch_err_o  = err_q;

  // Arbiter: fixed order from channel 0, or rotating after last winner
  reg [1:0] gnt_w, cand;
  reg       any_w;
  integer   k, r;
  always @*
  begin
    gnt_w = 2'h0;
    any_w = 1'b0;
    cand  = 2'h0;
    for (k = 3; k >= 0; k = k - 1)
    begin
      cand = prio_rr_i ? (last_q + 2'h1 + k[1:0]) : k[1:0];
      if (req_q[cand] & ~served_q[cand] & ~fin_q[cand] & ~fail_q[cand])
      begin
        gnt_w = cand;
        any_w = 1'b1;
      end
    end
  end

  // Granted channel's view: fresh config or running counters
  wire [15:0] cfg_src  = ch_src_addr_i[16*gnt_w +: 16];
  wire [15:0] cfg_dst  = ch_dst_addr_i[16*gnt_w +: 16];
  wire [15:0] cfg_blk  = ch_blk_size_i[16*gnt_w +: 16];
  wire [7:0]  cfg_rep  = ch_repeat_i[8*gnt_w +: 8];
  wire [16:0] full_blk = (cfg_blk == 16'h0000) ? `TC_BLK_FULL
                                               : {1'b0, cfg_blk};
  wire [15:0] g_src    = act_q[gnt_w] ? src_q[gnt_w] : cfg_src;
  wire [15:0] g_dst    = act_q[gnt_w] ? dst_q[gnt_w] : cfg_dst;
  wire [16:0] g_blk    = act_q[gnt_w] ? blk_q[gnt_w] : full_blk;
  wire [1:0]  bcode    = ch_burst_i[2*gnt_w +: 2];
  wire [3:0]  bsize    = 4'h1 << bcode;
  wire [3:0]  g_len    = (g_blk < {13'h0000, bsize}) ? g_blk[3:0]
                                                     : bsize;
  // Writes into the read-only window, or reads while unmapped, are illegal
  wire        bad_w    = in_nvm(g_dst) |
                         (in_nvm(g_src) & ~nvm_mapped_i);

  // Current channel's settings during the burst
  wire [1:0]  c_smode  = ch_src_mode_i[2*ch_q +: 2];
  wire [1:0]  c_dmode  = ch_dst_mode_i[2*ch_q +: 2];
  wire [1:0]  c_srl    = ch_src_reload_i[2*ch_q +: 2];
  wire [1:0]  c_drl    = ch_dst_reload_i[2*ch_q +: 2];
  wire [16:0] blk_left = blk_q[ch_q] - {13'h0000, len_q};
  wire        blk_end  = (blk_left == 17'h00000);
  wire        trn_end  = blk_end & (rep_q[ch_q] == 9'h001);
  wire [15:0] c_blk    = ch_blk_size_i[16*ch_q +: 16];
  wire        src_rl   = (c_srl == `TC_RL_BURST) |
                         (blk_end & (c_srl == `TC_RL_BLOCK)) |
                         (trn_end & (c_srl == `TC_RL_TRANS));
  wire        dst_rl   = (c_drl == `TC_RL_BURST) |
                         (blk_end & (c_drl == `TC_RL_BLOCK)) |
                         (trn_end & (c_drl == `TC_RL_TRANS));
  wire        bus_bad  = ((state_q == ST_RD) | (state_q == ST_WR)) &
                         bus_err_i;

  // FIFO hand-off: reads fill it, writes drain it
  assign push_w  = (state_q == ST_RD) & bus_ack_i & ~bus_err_i;
  assign pop_w   = (state_q == ST_WR) & bus_ack_i & ~bus_err_i;
  assign flush_w = bus_bad;

  tc_fifo
  #(
    .W  (`TC_DW),
    .D  (`TC_FIFO_D),
    .AW (`TC_FIFO_AW)
  )
  u_fifo
  (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .flush_i     (flush_w),
    .in_valid_i  (push_w),
    .in_ready_o  (fifo_in_rdy),
    .in_data_i   (bus_rdata_i),
    .out_valid_o (fifo_out_vld),
    .out_ready_i (pop_w),
    .out_data_o  (fifo_out)
  );

  // Main engine: grant, byte moves, burst and block close-out
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q     <= ST_IDLE;
      ch_q        <= 2'h0;
      last_q      <= 2'h3;
      len_q       <= 4'h0;
      rd_n_q      <= 4'h0;
      wr_n_q      <= 4'h0;
      act_q       <= 4'h0;
      served_q    <= 4'h0;
      fin_q       <= 4'h0;
      fail_q      <= 4'h0;
      bus_addr_o  <= 16'h0000;
      bus_rd_o    <= 1'b0;
      bus_wr_o    <= 1'b0;
      bus_wdata_o <= 8'h00;
      crc_valid_o <= 1'b0;
      crc_data_o  <= 8'h00;
      for (r = 0; r < 4; r = r + 1)
      begin
        src_q[r] <= 16'h0000;
        dst_q[r] <= 16'h0000;
        blk_q[r] <= 17'h00000;
        rep_q[r] <= 9'h000;
      end
    end
    else
    begin
      served_q    <= 4'h0;
      fin_q       <= 4'h0;
      fail_q      <= 4'h0;
      crc_valid_o <= 1'b0;
      if (bus_bad)
      begin
        // Bus error stops the channel and drops buffered bytes
        bus_rd_o      <= 1'b0;
        bus_wr_o      <= 1'b0;
        act_q[ch_q]   <= 1'b0;
        fail_q[ch_q]  <= 1'b1;
        state_q       <= ST_IDLE;
      end
      else
      begin
        case (state_q)
          ST_IDLE:
          begin
            if (any_w)
            begin
              ch_q            <= gnt_w;
              last_q          <= gnt_w;
              served_q[gnt_w] <= 1'b1;
              if (bad_w)
              begin
                act_q[gnt_w]  <= 1'b0;
                fail_q[gnt_w] <= 1'b1;
              end
              else
              begin
                // Private per-channel copies of start state
                if (!act_q[gnt_w])
                begin
                  src_q[gnt_w] <= cfg_src;
                  dst_q[gnt_w] <= cfg_dst;
                  blk_q[gnt_w] <= full_blk;
                  rep_q[gnt_w] <= {(cfg_rep == 8'h00), cfg_rep};
                end
                act_q[gnt_w] <= 1'b1;
                len_q        <= g_len;
                rd_n_q       <= g_len;
                wr_n_q       <= g_len;
                state_q      <= ST_RUN;
              end
            end
          end
          ST_RUN:
          begin
            // Reads go ahead while the FIFO has room, so it fills first
            if (wr_n_q == 4'h0)
              state_q <= ST_END;
            else if ((rd_n_q != 4'h0) & fifo_in_rdy)
            begin
              bus_addr_o <= src_q[ch_q];
              bus_rd_o   <= 1'b1;
              state_q    <= ST_RD;
            end
            else if (fifo_out_vld)
            begin
              bus_addr_o  <= dst_q[ch_q];
              bus_wdata_o <= fifo_out;
              bus_wr_o    <= 1'b1;
              state_q     <= ST_WR;
            end
          end
          ST_RD:
          begin
            if (bus_ack_i)
            begin
              bus_rd_o     <= 1'b0;
              src_q[ch_q]  <= step_addr(src_q[ch_q], c_smode);
              rd_n_q       <= rd_n_q - 4'h1;
              crc_valid_o  <= ch_crc_en_i[ch_q];
              crc_data_o   <= bus_rdata_i;
              state_q      <= ST_RUN;
            end
          end
          ST_WR:
          begin
            if (bus_ack_i)
            begin
              bus_wr_o     <= 1'b0;
              dst_q[ch_q]  <= step_addr(dst_q[ch_q], c_dmode);
              wr_n_q       <= wr_n_q - 4'h1;
              state_q      <= ST_RUN;
            end
          end
          ST_END:
          begin
            // Burst done: only now may another channel win the bus
            if (src_rl)
              src_q[ch_q] <= ch_src_addr_i[16*ch_q +: 16];
            if (dst_rl)
              dst_q[ch_q] <= ch_dst_addr_i[16*ch_q +: 16];
            if (trn_end)
            begin
              act_q[ch_q] <= 1'b0;
              fin_q[ch_q] <= 1'b1;
            end
            else if (blk_end)
            begin
              rep_q[ch_q] <= rep_q[ch_q] - 9'h001;
              blk_q[ch_q] <= (c_blk == 16'h0000) ? `TC_BLK_FULL
                                                 : {1'b0, c_blk};
            end
            else
              blk_q[ch_q] <= blk_left;
            state_q <= ST_IDLE;
          end
          default:
            state_q <= ST_IDLE;
        endcase
      end
    end
  end

endmodule // tc_engine

// ### common/tc_map.vh
// Constants for the four-channel transfer controller.
// Assumes a flat 16-bit byte address space with one data bus master.
`ifndef TC_MAP_VH
`define TC_MAP_VH

// Channel count and field widths
`define TC_NCH        4
`define TC_AW         16
`define TC_DW         8
`define TC_BLKW       17
`define TC_REPW       9

// Memory-mapped non-volatile storage window, read only
`define TC_NVM_LO     16'h1000
`define TC_NVM_HI     16'h1FFF

// Address modes
`define TC_AM_FIXED   2'h0
`define TC_AM_INC     2'h1
`define TC_AM_DEC     2'h2

// Address reload points
`define TC_RL_NONE    2'h0
`define TC_RL_BURST   2'h1
`define TC_RL_BLOCK   2'h2
`define TC_RL_TRANS   2'h3

// Trigger sources
`define TC_TR_SW      2'h0
`define TC_TR_PERIPH  2'h1
`define TC_TR_EVENT   2'h2

// Block size of zero means the full 64K bytes
`define TC_BLK_FULL   17'h10000

// Data FIFO geometry
`define TC_FIFO_D     4
`define TC_FIFO_AW    2

`endif

// ### logic/tc_fifo.v
// Small byte FIFO in the transfer data path, flip-flop storage.
// Assumes one clock; flush drops contents in one edge.
`timescale 1ns/1ns
module tc_fifo
#(
  parameter W  = 8,
  parameter D  = 4,
  parameter AW = 2
)
(
  input  wire         ref_clk_i,
  input  wire         rst_n_i,
  input  wire         flush_i,
  input  wire         in_valid_i,
  output wire         in_ready_o,
  input  wire [W-1:0] in_data_i,
  output wire         out_valid_o,
  input  wire         out_ready_i,
  output wire [W-1:0] out_data_o
);

  reg [W-1:0] mem_q [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0]   cnt_q;
  wire         push_w;
  wire         pop_w;

  // Full and empty straight from the count
  assign in_ready_o  = (cnt_q != D[AW:0]);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o  = mem_q[rp_q];
  assign push_w      = in_valid_i & in_ready_o;
  assign pop_w       = out_ready_i & out_valid_o;

  // Storage, written only at the write pointer
  always @(posedge ref_clk_i)
  begin
    if (push_w)
      mem_q[wp_q] <= in_data_i;
  end

  // Pointers and count; flush wins over traffic
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else if (flush_i)
    begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push_w)
        wp_q <= wp_q + {{(AW-1){1'b0}}, 1'b1};
      if (pop_w)
        rp_q <= rp_q + {{(AW-1){1'b0}}, 1'b1};
      if (push_w & ~pop_w)
        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
      else if (pop_w & ~push_w)
        cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
    end
  end

endmodule // tc_fifo

// ### sim/tc_engine_properties.sv
// Bus, CRC and flag checks for the transfer controller.
// Assumes it is bound onto tc_engine; one clock, async low reset.
`timescale 1ns/1ns
`include "tc_map.vh"
module tc_engine_chk
(
  input wire        ref_clk_i,
  input wire        rst_n_i,
  input wire [3:0]  ch_en_i,
  input wire [7:0]  ch_trig_sel_i,
  input wire [3:0]  sw_trig_i,
  input wire        prio_rr_i,
  input wire [3:0]  ch_irq_done_en_i,
  input wire [3:0]  ch_irq_err_en_i,
  input wire [3:0]  done_clr_i,
  input wire [3:0]  err_clr_i,
  input wire        nvm_mapped_i,
  input wire [15:0] bus_addr_o,
  input wire        bus_rd_o,
  input wire        bus_wr_o,
  input wire [7:0]  bus_wdata_o,
  input wire [7:0]  bus_rdata_i,
  input wire        bus_ack_i,
  input wire        bus_err_i,
  input wire        crc_valid_o,
  input wire [7:0]  crc_data_o,
  input wire [3:0]  ch_busy_o,
  input wire [3:0]  ch_done_o,
  input wire [3:0]  ch_err_o,
  input wire [3:0]  irq_done_o,
  input wire [3:0]  irq_err_o
);
  // Single domain, so clock and reset are stated once
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Access end and storage window decode
  wire ends  = bus_ack_i | bus_err_i;
  wire nvm_a = (bus_addr_o >= `TC_NVM_LO) && (bus_addr_o <= `TC_NVM_HI);

  property p_rd_hold;
    bus_rd_o && !ends |=> bus_rd_o && $stable(bus_addr_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read not held until answer");
  property p_wr_hold;
    bus_wr_o && !ends |=> bus_wr_o && $stable({bus_addr_o, bus_wdata_o});
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("write not held until answer");
  property p_end;
    (bus_rd_o || bus_wr_o) && ends |=> !bus_rd_o && !bus_wr_o;
  endproperty
  a_end: assert property (p_end)
    else $error("access not ended after answer");
  property p_crc;
    crc_valid_o |-> $past(bus_rd_o && bus_ack_i)
                    && crc_data_o == $past(bus_rdata_i);
  endproperty
  a_crc: assert property (p_crc)
    else $error("crc byte not the byte just read");
  property p_irq;
    irq_done_o == (ch_done_o & ch_irq_done_en_i)
    && irq_err_o == (ch_err_o & ch_irq_err_en_i);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt not flag and enable");
  property p_nvm_wr;
    bus_wr_o |-> !nvm_a;
  endproperty
  a_nvm_wr: assert property (p_nvm_wr)
    else $error("write into read-only storage");
  property p_nvm_rd;
    bus_rd_o && !nvm_mapped_i |-> !nvm_a;
  endproperty
  a_nvm_rd: assert property (p_nvm_rd)
    else $error("read of unmapped storage");
  property p_sticky;
    (($past(ch_done_o) & ~ch_done_o & ~$past(done_clr_i))
     | ($past(ch_err_o) & ~ch_err_o & ~$past(err_clr_i))) == 4'h0;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag fell without clear");
  property p_start;
    ch_en_i[0] && sw_trig_i[0] && ch_trig_sel_i[1:0] == 2'h0 && !prio_rr_i
    && ch_busy_o == 4'h0 && !bus_rd_o && !bus_wr_o
    |-> ##[1:4] (ch_busy_o[0] || ch_err_o[0]);
  endproperty
  a_start: assert property (p_start)
    else $error("software start not taken");
endmodule // tc_engine_chk

bind tc_engine tc_engine_chk i_chk
(
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ch_en_i(ch_en_i),
  .ch_trig_sel_i(ch_trig_sel_i), .sw_trig_i(sw_trig_i),
  .prio_rr_i(prio_rr_i), .ch_irq_done_en_i(ch_irq_done_en_i),
  .ch_irq_err_en_i(ch_irq_err_en_i), .done_clr_i(done_clr_i),
  .err_clr_i(err_clr_i), .nvm_mapped_i(nvm_mapped_i),
  .bus_addr_o(bus_addr_o), .bus_rd_o(bus_rd_o), .bus_wr_o(bus_wr_o),
  .bus_wdata_o(bus_wdata_o), .bus_rdata_i(bus_rdata_i),
  .bus_ack_i(bus_ack_i), .bus_err_i(bus_err_i),
  .crc_valid_o(crc_valid_o), .crc_data_o(crc_data_o),
  .ch_busy_o(ch_busy_o), .ch_done_o(ch_done_o), .ch_err_o(ch_err_o),
  .irq_done_o(irq_done_o), .irq_err_o(irq_err_o)
);

// ### sim/tc_mem_model.sv
// Byte memory and register space answering the controller bus.
// Assumes rd/wr held until answered; wait states set by the bench.
`timescale 1ns/1ns
module tc_mem_model
(
  input  wire        ref_clk_i,
  input  wire        rst_n_i,
  input  wire [3:0]  wait_i,
  input  wire        err_en_i,
  input  wire [15:0] err_addr_i,
  input  wire [15:0] bus_addr_i,
  input  wire        bus_rd_i,
  input  wire        bus_wr_i,
  input  wire [7:0]  bus_wdata_i,
  output reg  [7:0]  bus_rdata_o,
  output reg         bus_ack_o,
  output reg         bus_err_o
);
  reg  [7:0] mem [0:65535];
  reg  [3:0] cnt_q;
  wire       req = (bus_rd_i | bus_wr_i) & ~bus_ack_o & ~bus_err_o;

  // Read data valid only with ack; toggles otherwise so stale use shows
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q       <= 4'h0;
      bus_ack_o   <= 1'b0;
      bus_err_o   <= 1'b0;
      bus_rdata_o <= 8'hA5;
    end
    else
    begin
      bus_ack_o   <= 1'b0;
      bus_err_o   <= 1'b0;
      bus_rdata_o <= ~bus_rdata_o;
      cnt_q       <= 4'h0;
      if (req && cnt_q < wait_i)
        cnt_q <= cnt_q + 4'h1;
      else if (req && err_en_i && bus_addr_i == err_addr_i)
        bus_err_o <= 1'b1;
      else if (req)
      begin
        bus_ack_o <= 1'b1;
        if (bus_rd_i)
          bus_rdata_o <= mem[bus_addr_i];
        if (bus_wr_i)
          mem[bus_addr_i] <= bus_wdata_i;
      end
    end
  end
endmodule // tc_mem_model

// ### sim/test_tc_engine.sv
// Self-checking bench for tc_engine; results checked in bus memory.
// Assumes tc_mem_model on the far side and the checker bound in.
`timescale 1ns/1ns
`include "tc_map.vh"
`define TC_CHK(a, e) \
  begin \
    total_checks = total_checks + 1; \
    if ((a) !== (e)) \
    begin \
      num_errors = num_errors + 1; \
      $display("wrong value at %0t: %0h, expected %0h", $time, a, e); \
    end \
  end
module test_tc_engine;
  reg         ref_clk_i = 1'b0;
  reg         rst_n_i = 1'b0;
  reg  [63:0] src_a = 64'h0, dst_a = 64'h0, blk = 64'h0;
  reg  [31:0] rep = 32'h0;
  reg  [7:0]  bst = 8'h0, sm = 8'h0, dm = 8'h0, srl = 8'h0, drl = 8'h0;
  reg  [7:0]  trs = 8'h0;
  reg  [3:0]  ch_en = 4'hF, crc_en = 4'h1, ide = 4'h1, iee = 4'h0;
  reg  [3:0]  sw = 4'h0, pr = 4'h0, ev = 4'h0, dclr = 4'h0, eclr = 4'h0;
  reg  [3:0]  wait_n = 4'h0;
  reg  [1:0]  link = 2'h0;
  reg         nvm_map = 1'b1, err_en = 1'b0;
  reg  [15:0] err_adr = 16'h0;
  wire [15:0] addr;
  wire [7:0]  wdata, rdata, crcd;
  wire        rd, wr, ack, berr, crcv;
  wire [3:0]  busy, done, err, irqd, irqe;
  integer     num_errors = 0, total_checks = 0, crc_n = 0, i;

  tc_engine i_dut
  (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ch_en_i(ch_en),
    .ch_src_addr_i(src_a), .ch_dst_addr_i(dst_a), .ch_blk_size_i(blk),
    .ch_repeat_i(rep), .ch_burst_i(bst), .ch_src_mode_i(sm),
    .ch_dst_mode_i(dm), .ch_src_reload_i(srl), .ch_dst_reload_i(drl),
    .ch_trig_sel_i(trs), .ch_crc_en_i(crc_en), .ch_irq_done_en_i(ide),
    .ch_irq_err_en_i(iee), .sw_trig_i(sw), .periph_req_i(pr),
    .event_i(ev), .done_clr_i(dclr), .err_clr_i(eclr),
    .pair_link_i(link), .prio_rr_i(1'b0), .nvm_mapped_i(nvm_map),
    .bus_addr_o(addr), .bus_rd_o(rd), .bus_wr_o(wr), .bus_wdata_o(wdata),
    .bus_rdata_i(rdata), .bus_ack_i(ack), .bus_err_i(berr),
    .crc_valid_o(crcv), .crc_data_o(crcd), .ch_busy_o(busy),
    .ch_done_o(done), .ch_err_o(err), .irq_done_o(irqd), .irq_err_o(irqe)
  );
  tc_mem_model i_mem
  (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .wait_i(wait_n),
    .err_en_i(err_en), .err_addr_i(err_adr), .bus_addr_i(addr),
    .bus_rd_i(rd), .bus_wr_i(wr), .bus_wdata_i(wdata),
    .bus_rdata_o(rdata), .bus_ack_o(ack), .bus_err_o(berr)
  );

  // Clock, and a count of bytes offered to the checksum unit
  always #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i)
    if (crcv === 1'b1)
      crc_n <= crc_n + 1;

  // Memory contents are a known function of the address
  function [7:0] pat(input [15:0] a);
    pat = a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction

  task cfg(input integer c, input [15:0] s, input [15:0] d,
           input [15:0] b, input [7:0] r, input [1:0] u,
           input [3:0] md, input [3:0] rl, input [1:0] t);
    begin
      @(posedge ref_clk_i);
      src_a[16*c +: 16] <= s;
      dst_a[16*c +: 16] <= d;
      blk[16*c +: 16]   <= b;
      rep[8*c +: 8]     <= r;
      bst[2*c +: 2]     <= u;
      sm[2*c +: 2]      <= md[1:0];
      dm[2*c +: 2]      <= md[3:2];
      srl[2*c +: 2]     <= rl[1:0];
      drl[2*c +: 2]     <= rl[3:2];
      trs[2*c +: 2]     <= t;
    end
  endtask

  // One-cycle pulse: 0 software, 1 event, 2 done clear, 3 error clear
  task pulse(input integer k, input [3:0] m);
    begin
      @(posedge ref_clk_i);
      case (k)
        0: sw <= m;
        1: ev <= m;
        2: dclr <= m;
        default: eclr <= m;
      endcase
      @(posedge ref_clk_i);
      sw   <= 4'h0;
      ev   <= 4'h0;
      dclr <= 4'h0;
      eclr <= 4'h0;
      #1;
    end
  endtask

  // Bounded wait for done or error on every channel in the mask
  task wait_flags(input [3:0] m);
    integer n;
    begin
      n = 0;
      while (((done | err) & m) !== m && n < 3000)
      begin
        @(posedge ref_clk_i);
        #1;
        n = n + 1;
      end
      if (n >= 3000)
        num_errors = num_errors + 1;
    end
  endtask

  task chk_mem(input integer s, input integer d, input integer n,
               input integer wrap, input integer stp);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1)
        `TC_CHK(i_mem.mem[d + k], pat(s + stp * (k % wrap)));
    end
  endtask

  task finish_test;
    begin
      $display("checks %0d, errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // Hang guard; all tests together need well under a thousand cycles
  initial
  begin
    repeat (30000) @(posedge ref_clk_i);
    num_errors = num_errors + 1;
    finish_test;
  end

  initial
  begin
    for (i = 0; i < 65536; i = i + 1)
      i_mem.mem[i] = pat(i[15:0]);
    repeat (8) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    // Four channels started together, each with its own modes
    cfg(0, 16'h2000, 16'h3000, 16'h0008, 8'h02, 2'h3, 4'h5, 4'h2, 2'h0);
    cfg(1, 16'h2107, 16'h3100, 16'h0003, 8'h01, 2'h1, 4'h6, 4'h0, 2'h0);
    cfg(2, 16'h2200, 16'h0040, 16'h0004, 8'h01, 2'h0, 4'h1, 4'h0, 2'h0);
    cfg(3, 16'h1010, 16'h3300, 16'h0004, 8'h01, 2'h2, 4'h5, 4'hF, 2'h0);
    pulse(0, 4'hF);
    wait_flags(4'hF);
    `TC_CHK(done, 4'hF);
    `TC_CHK(err, 4'h0);
    `TC_CHK(irqd, 4'h1);
    chk_mem(16'h2000, 16'h3000, 16, 8, 1);
    chk_mem(16'h2107, 16'h3100, 3, 3, -1);
    `TC_CHK(i_mem.mem[16'h0040], pat(16'h2203));
    chk_mem(16'h1010, 16'h3300, 4, 4, 1);
    `TC_CHK(crc_n, 16);
    pulse(2, 4'hF);
    `TC_CHK(done, 4'h0);
    // Event pulses and a held peripheral request, slow slave
    cfg(1, 16'h2400, 16'h3400, 16'h0003, 8'h01, 2'h0, 4'h5, 4'h0, 2'h2);
    cfg(2, 16'h2500, 16'h3500, 16'h0004, 8'h01, 2'h2, 4'h5, 4'h0, 2'h1);
    wait_n <= 4'h3;
    ch_en  <= 4'h6;
    pr     <= 4'h4;
    // Gap longer than a slow burst, so each event is served on its own
    for (i = 0; i < 2; i = i + 1)
    begin
      pulse(1, 4'h2);
      repeat (100) @(posedge ref_clk_i);
    end
    #1;
    `TC_CHK(done[1], 1'b0);
    pulse(1, 4'h2);
    wait_flags(4'h6);
    pr <= 4'h0;
    chk_mem(16'h2400, 16'h3400, 3, 3, 1);
    chk_mem(16'h2500, 16'h3500, 4, 4, 1);
    // Software start on a disabled channel is ignored
    pulse(0, 4'h8);
    repeat (60) @(posedge ref_clk_i);
    #1;
    `TC_CHK(busy[3] | done[3], 1'b0);
    // Storage read while unmapped, then interrupt enable and clear
    cfg(3, 16'h1010, 16'h3600, 16'h0004, 8'h01, 2'h2, 4'h5, 4'h0, 2'h0);
    wait_n  <= 4'h0;
    nvm_map <= 1'b0;
    ch_en   <= 4'h8;
    pulse(0, 4'h8);
    wait_flags(4'h8);
    `TC_CHK(err, 4'h8);
    `TC_CHK(irqe, 4'h0);
    @(posedge ref_clk_i);
    iee <= 4'h8;
    @(posedge ref_clk_i);
    #1;
    `TC_CHK(irqe, 4'h8);
    pulse(3, 4'h8);
    `TC_CHK(err, 4'h0);
    // Destination inside read-only storage
    cfg(3, 16'h2000, 16'h1800, 16'h0004, 8'h01, 2'h2, 4'h5, 4'h0, 2'h0);
    pulse(0, 4'h8);
    wait_flags(4'h8);
    `TC_CHK(err, 4'h8);
    pulse(3, 4'h8);
    // Bus error on the third read of an 8-byte burst
    cfg(3, 16'h2000, 16'h3700, 16'h0008, 8'h01, 2'h3, 4'h5, 4'h0, 2'h0);
    err_en  <= 1'b1;
    err_adr <= 16'h2002;
    pulse(0, 4'h8);
    wait_flags(4'h8);
    `TC_CHK({busy[3], err[3], done[3]}, 3'b010);
    `TC_CHK(i_mem.mem[16'h3700], pat(16'h3700));
    err_en <= 1'b0;
    pulse(3, 4'h8);
    // Linked pair: each finish starts the other
    cfg(0, 16'h2000, 16'h3800, 16'h0001, 8'h01, 2'h0, 4'h5, 4'h0, 2'h0);
    cfg(1, 16'h2001, 16'h3801, 16'h0001, 8'h01, 2'h0, 4'h5, 4'h0, 2'h3);
    link  <= 2'h1;
    ch_en <= 4'h3;
    pulse(2, 4'hF);
    pulse(0, 4'h1);
    wait_flags(4'h2);
    `TC_CHK(done[1:0], 2'h3);
    pulse(2, 4'h3);
    wait_flags(4'h1);
    `TC_CHK(done[0], 1'b1);
    `TC_CHK(i_mem.mem[16'h3801], pat(16'h2001));
    link <= 2'h0;
    repeat (60) @(posedge ref_clk_i);
    finish_test;
  end
endmodule // test_tc_engine
